// [indicator_blink_and_rail_config_regs_defines.svh]
// Register offsets, field positions, reset values and timing figures.
`ifndef INDICATOR_BLINK_AND_RAIL_CONFIG_REGS_DEFINES_SVH
`define INDICATOR_BLINK_AND_RAIL_CONFIG_REGS_DEFINES_SVH

// Register offsets.
`define ADDR_PG_ON 8'h08
`define ADDR_PG_PER 8'h09
`define ADDR_B_ON 8'h0a
`define ADDR_B_PER 8'h0b
`define ADDR_IO_CFG 8'h0c
`define ADDR_PROC_CFG 8'h0d

// Reset values; strap bits are loaded after reset release.
`define RST_PG_ON 8'h00
`define RST_PG_PER 8'h00
`define RST_B_ON 8'h00
`define RST_B_PER 8'h00
`define RST_IO_CFG 8'h32
`define RST_PROC_CFG 8'h60
`define RD_UNMAPPED 8'h00

// Indicator register fields.
`define BIT_SEL 7
`define TIME_HI 6
`define TIME_LO 0

// I/O rail converter register fields.
`define BIT_FFORCE 7
`define UVLO_HI 6
`define UVLO_LO 5
`define BIT_SUPPLY_SEL 4
`define BIT_SLEEP_EN 3
`define BIT_IO_DISCH 2
`define IO_CODE_HI 1
`define IO_CODE_LO 0
`define BIT_IO_STRAP 0

// Processor rail converter register fields.
`define BIT_PROC_OFF_LP 7
`define PROC_CODE_HI 6
`define PROC_CODE_LO 4
`define PROC_LP_HI 3
`define PROC_LP_LO 2
`define BIT_MOTOR 1
`define BIT_PROC_DISCH 0
`define BIT_PROC_STRAP 4

// Timing figures.
`define CLK_PERIOD_NS 40
`define TICK_MS 10
`define NS_PER_MS 1000000
`define ON_STEP_MS 10
`define PER_STEP_MS 100

`endif

// [indicator_blink_and_rail_config_regs_pkg.sv]
// Types shared by the indicator and rail configuration register bank.
package indicator_blink_and_rail_config_regs_pkg;

    // Gray-ordered indicator behaviour: charger, blink, on, off.
    typedef enum logic [1:0] {
        IND_CHARGER = 2'h0,
        IND_BLINK = 2'h1,
        IND_ON = 2'h3,
        IND_OFF = 2'h2
    } ind_mode_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [10:0] tick_count_t;

endpackage

// [indicator_blink_and_rail_config_regs.sv]
// Indicator blink generators and step-down converter configuration registers.
`timescale 1ns/1ps
`include "indicator_blink_and_rail_config_regs_defines.svh"

module indicator_blink_and_rail_config_regs #(
    parameter int TICK_CYCLES = `TICK_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
    // Clock, reset and clock enable.
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    // Register port from the serial interface.
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Device pins and charger status.
    input wire logic sleepReqPin,
    input wire logic ioRailStrap,
    input wire logic procRailStrap,
    input wire logic chargerPgOn,
    // Open-drain indicator pins.
    output logic pgPinOut,
    output logic pgPinOe,
    output logic indBPinOut,
    output logic indBPinOe,
    // Converter controls.
    output logic fixedFreqForce,
    output logic [1:0] uvloSel,
    output logic lowPowerMode,
    output logic waitMode,
    output logic ioRailEnable,
    output logic ioRailDischarge,
    output logic [1:0] ioRailCode,
    output logic procRailEnable,
    output logic procRailDischarge,
    output logic [2:0] procRailCode,
    output logic motorDrive
);
    import indicator_blink_and_rail_config_regs_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam tick_count_t ON_STEP = 11'(`ON_STEP_MS / `TICK_MS);
    localparam tick_count_t PER_STEP = 11'(`PER_STEP_MS / `TICK_MS);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    function automatic tick_count_t stepTicks(input logic [6:0] field,
                                              input tick_count_t step);
        logic [21:0] prod;
        prod = ({15'h0000, field} + 22'h000001) * {11'h000, step};
        stepTicks = prod[10:0];
    endfunction

    function automatic tick_count_t nextPhase(input tick_count_t phase,
                                              input tick_count_t period);
        tick_count_t inc;
        inc = phase + 11'h001;
        if (inc >= period) begin
            nextPhase = 11'h000;
        end else begin
            nextPhase = inc;
        end
    endfunction

    function automatic ind_mode_t decodeMode(input logic hi, input logic lo,
                                             input logic chargerAllowed);
        unique case ({hi, lo})
            2'h0: decodeMode = chargerAllowed ? IND_CHARGER : IND_OFF;
            2'h1: decodeMode = IND_BLINK;
            2'h2: decodeMode = IND_OFF;
            2'h3: decodeMode = IND_ON;
        endcase
    endfunction

    function automatic logic indicatorLit(input ind_mode_t mode,
                                          input logic chargerOn,
                                          input tick_count_t phase,
                                          input tick_count_t onTicks);
        unique case (mode)
            IND_CHARGER: indicatorLit = chargerOn;
            IND_BLINK: indicatorLit = (phase < onTicks);
            IND_ON: indicatorLit = 1'b1;
            IND_OFF: indicatorLit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    reg_byte_t pgOn_r, pgOn_nxt;
    reg_byte_t pgPer_r, pgPer_nxt;
    reg_byte_t bOn_r, bOn_nxt;
    reg_byte_t bPer_r, bPer_nxt;
    reg_byte_t ioCfg_r, ioCfg_nxt;
    reg_byte_t procCfg_r, procCfg_nxt;
    logic strapDone_r, strapDone_nxt;

    always_comb begin
        pgOn_nxt = pgOn_r;
        pgPer_nxt = pgPer_r;
        bOn_nxt = bOn_r;
        bPer_nxt = bPer_r;
        ioCfg_nxt = ioCfg_r;
        procCfg_nxt = procCfg_r;
        strapDone_nxt = 1'b1;
        // Straps are caught once, on the first enabled edge after release,
        // so the reset itself only ever loads constants.
        if (!strapDone_r) begin
            ioCfg_nxt[`BIT_IO_STRAP] = ioRailStrap;
            procCfg_nxt[`BIT_PROC_STRAP] = procRailStrap;
        end else if (regWrEn) begin
            unique case (regAddr)
                `ADDR_PG_ON: pgOn_nxt = regWrData;
                `ADDR_PG_PER: pgPer_nxt = regWrData;
                `ADDR_B_ON: bOn_nxt = regWrData;
                `ADDR_B_PER: bPer_nxt = regWrData;
                `ADDR_IO_CFG: ioCfg_nxt = regWrData;
                `ADDR_PROC_CFG: procCfg_nxt = regWrData;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pgOn_r <= `RST_PG_ON;
            pgPer_r <= `RST_PG_PER;
            bOn_r <= `RST_B_ON;
            bPer_r <= `RST_B_PER;
            ioCfg_r <= `RST_IO_CFG;
            procCfg_r <= `RST_PROC_CFG;
            strapDone_r <= 1'b0;
        end else if (clkEn) begin
            pgOn_r <= pgOn_nxt;
            pgPer_r <= pgPer_nxt;
            bOn_r <= bOn_nxt;
            bPer_r <= bPer_nxt;
            ioCfg_r <= ioCfg_nxt;
            procCfg_r <= procCfg_nxt;
            strapDone_r <= strapDone_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, one cycle behind the address.

    reg_byte_t rdData_r, rdData_nxt;

    always_comb begin
        unique case (regAddr)
            `ADDR_PG_ON: rdData_nxt = pgOn_r;
            `ADDR_PG_PER: rdData_nxt = pgPer_r;
            `ADDR_B_ON: rdData_nxt = bOn_r;
            `ADDR_B_PER: rdData_nxt = bPer_r;
            `ADDR_IO_CFG: rdData_nxt = ioCfg_r;
            `ADDR_PROC_CFG: rdData_nxt = procCfg_r;
            default: rdData_nxt = `RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdData_r <= `RD_UNMAPPED;
        end else if (clkEn) begin
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    ////////////////////////////////////////////////////////////////////////
    // Ten-millisecond tick shared by both blink generators.

    logic [TW-1:0] tickCnt_r, tickCnt_nxt;
    logic tick_r, tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        if (tickCnt_r == TW'(TICK_CYCLES - 1)) begin
            tickCnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            tickCnt_nxt = tickCnt_r + TW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tickCnt_r <= '0;
            tick_r <= 1'b0;
        end else if (clkEn) begin
            tickCnt_r <= tickCnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Blink generators.

    ind_mode_t pgMode, bMode;
    tick_count_t pgOnTicks, pgPerTicks, bOnTicks, bPerTicks;
    tick_count_t pgPhase_r, pgPhase_nxt;
    tick_count_t bPhase_r, bPhase_nxt;

    assign pgMode = decodeMode(pgOn_r[`BIT_SEL], pgPer_r[`BIT_SEL],
                               1'b1);
    assign bMode = decodeMode(bOn_r[`BIT_SEL], bPer_r[`BIT_SEL], 1'b0);
    assign pgOnTicks = stepTicks(pgOn_r[`TIME_HI:`TIME_LO], ON_STEP);
    assign pgPerTicks = stepTicks(pgPer_r[`TIME_HI:`TIME_LO],
                                  PER_STEP);
    assign bOnTicks = stepTicks(bOn_r[`TIME_HI:`TIME_LO], ON_STEP);
    assign bPerTicks = stepTicks(bPer_r[`TIME_HI:`TIME_LO], PER_STEP);

    // Outside blink mode the phase is held at zero, so a fresh blink opens at phase zero, with an on-time
    // short of full only by the elapsed part of the free-running tick, instead of a random slice of the period.
    always_comb begin
        pgPhase_nxt = pgPhase_r;
        bPhase_nxt = bPhase_r;
        if (pgMode != IND_BLINK) begin
            pgPhase_nxt = 11'h000;
        end else if (tick_r) begin
            pgPhase_nxt = nextPhase(pgPhase_r, pgPerTicks);
        end
        if (bMode != IND_BLINK) begin
            bPhase_nxt = 11'h000;
        end else if (tick_r) begin
            bPhase_nxt = nextPhase(bPhase_r, bPerTicks);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pgPhase_r <= 11'h000;
            bPhase_r <= 11'h000;
        end else if (clkEn) begin
            pgPhase_r <= pgPhase_nxt;
            bPhase_r <= bPhase_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep request decode and converter controls.

    logic sleepReq, lowPwr, waitReq;
    logic procOff;
    logic pgLit_nxt, bLit_nxt;
    logic pgOe_r, bOe_r, pinLow_r;
    logic fForce_r, lpMode_r, waitMode_r, ioEn_r, ioDis_r;
    logic procEn_r, procDis_r, motor_r;
    logic [1:0] uvlo_r, ioCode_r;
    logic [2:0] procCode_r, procCode_nxt;

    assign sleepReq = sleepReqPin & ioCfg_r[`BIT_SLEEP_EN];
    assign lowPwr = sleepReq & ioCfg_r[`BIT_SUPPLY_SEL];
    assign waitReq = sleepReq & ~ioCfg_r[`BIT_SUPPLY_SEL];
    assign procOff = lowPwr & procCfg_r[`BIT_PROC_OFF_LP];

    always_comb begin
        pgLit_nxt = indicatorLit(pgMode, chargerPgOn, pgPhase_r, pgOnTicks);
        bLit_nxt = indicatorLit(bMode, 1'b0, bPhase_r, bOnTicks);
        if (lowPwr) begin
            procCode_nxt = {1'b0,
                procCfg_r[`PROC_LP_HI:`PROC_LP_LO]};
        end else begin
            procCode_nxt = procCfg_r[`PROC_CODE_HI:`PROC_CODE_LO];
        end
    end

    // Every output leaves through a flop, so the pins see two cycles of
    // latency after a register write and one after a sleep pin change.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pgOe_r <= 1'b0;
            bOe_r <= 1'b0;
            pinLow_r <= 1'b0;
            fForce_r <= 1'b0;
            uvlo_r <= 2'h0;
            lpMode_r <= 1'b0;
            waitMode_r <= 1'b0;
            ioEn_r <= 1'b0;
            ioDis_r <= 1'b0;
            ioCode_r <= 2'h0;
            procEn_r <= 1'b0;
            procDis_r <= 1'b0;
            procCode_r <= 3'h0;
            motor_r <= 1'b0;
        end else if (clkEn) begin
            pgOe_r <= pgLit_nxt;
            bOe_r <= bLit_nxt;
            pinLow_r <= 1'b0;
            fForce_r <= ioCfg_r[`BIT_FFORCE];
            uvlo_r <= ioCfg_r[`UVLO_HI:`UVLO_LO];
            lpMode_r <= lowPwr;
            waitMode_r <= waitReq;
            ioEn_r <= ~waitReq;
            ioDis_r <= ioCfg_r[`BIT_IO_DISCH] & waitReq;
            ioCode_r <= ioCfg_r[`IO_CODE_HI:`IO_CODE_LO];
            procEn_r <= ~waitReq & ~procOff;
            procDis_r <= procCfg_r[`BIT_PROC_DISCH] &
                (waitReq | procOff);
            procCode_r <= procCode_nxt;
            motor_r <= procCfg_r[`BIT_MOTOR];
        end
    end

    assign pgPinOe = pgOe_r;
    assign pgPinOut = pinLow_r;
    assign indBPinOe = bOe_r;
    assign indBPinOut = pinLow_r;
    assign fixedFreqForce = fForce_r;
    assign uvloSel = uvlo_r;
    assign lowPowerMode = lpMode_r;
    assign waitMode = waitMode_r;
    assign ioRailEnable = ioEn_r;
    assign ioRailDischarge = ioDis_r;
    assign ioRailCode = ioCode_r;
    assign procRailEnable = procEn_r;
    assign procRailDischarge = procDis_r;
    assign procRailCode = procCode_r;
    assign motorDrive = motor_r;

endmodule

// [rail_regs_properties.sv]
// Concurrent checks on the converter control outputs of the register bank.
`timescale 1ns/1ps
module rail_regs_properties #(
    parameter int TICK_CYCLES = 250000
) (
    // Clock, reset and register port.
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    // Sleep pin and converter controls.
    input wire logic sleepReqPin,
    input wire logic fixedFreqForce,
    input wire logic lowPowerMode,
    input wire logic waitMode,
    input wire logic ioRailEnable,
    input wire logic ioRailDischarge,
    input wire logic procRailEnable,
    input wire logic procRailDischarge,
    input wire logic [2:0] procRailCode,
    input wire logic motorDrive
);
    default clocking cb @(posedge clk_sys);
    endclocking
    // Frozen cycles are left out, since a write then is dropped on purpose.
    default disable iff (!resetn || !clkEn);
    // A write lands in the register at once; the output follows one edge on.
    a_motor_follows_write: assert property (
        regWrEn && regAddr == 8'h0d ##1 1'b1 |=>
        motorDrive == $past(regWrData[1], 2)) else $error("motor drive");
    a_proc_code_write: assert property (
        regWrEn && regAddr == 8'h0d ##1 1'b1 |=>
        lowPowerMode || procRailCode == $past(regWrData[6:4], 2))
        else $error("proc code");
    a_force_follows_write: assert property (
        regWrEn && regAddr == 8'h0c ##1 1'b1 |=>
        fixedFreqForce == $past(regWrData[7], 2)) else $error("force");
    a_sleep_needs_pin: assert property (
        lowPowerMode || waitMode |-> $past(sleepReqPin))
        else $error("sleep without pin");
    a_modes_exclusive: assert property (
        !(lowPowerMode && waitMode)) else $error("both modes");
    a_io_off_wait: assert property (
        $past(resetn) |-> ioRailEnable == !waitMode) else $error("io enable");
    a_io_discharge_wait: assert property (
        ioRailDischarge |-> waitMode && !ioRailEnable)
        else $error("io discharge");
    a_proc_discharge_cause: assert property (
        procRailDischarge |-> waitMode || lowPowerMode && !procRailEnable)
        else $error("proc discharge");
    a_sleep_code_top: assert property (
        lowPowerMode |-> !procRailCode[2]) else $error("sleep code");
endmodule
bind indicator_blink_and_rail_config_regs rail_regs_properties #(
    .TICK_CYCLES(TICK_CYCLES)) rail_regs_properties_i (
    .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .sleepReqPin(sleepReqPin),
    .fixedFreqForce(fixedFreqForce), .lowPowerMode(lowPowerMode),
    .waitMode(waitMode), .ioRailEnable(ioRailEnable),
    .ioRailDischarge(ioRailDischarge), .procRailEnable(procRailEnable),
    .procRailDischarge(procRailDischarge), .procRailCode(procRailCode),
    .motorDrive(motorDrive));

// [indicator_lamp_model.sv]
// Lamp on an open-drain indicator pin with a pull-up to the supply.
`timescale 1ns/1ps
module indicator_lamp_model (
    // Pin drive from the device.
    input wire logic pinOut,
    input wire logic pinOe,
    // Lamp state.
    output wire logic lit
);
    // The pull-up sets the level whenever the transistor is off.
    assign lit = pinOe ? !pinOut : 1'b0;
endmodule

// [tb_top.sv]
// Self-checking bench for the indicator and rail register bank.
`timescale 1ns/1ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
    import indicator_blink_and_rail_config_regs_pkg::*;
    typedef struct {int kind; logic [15:0] exp; string what;} note_t;
    localparam reg_byte_t RV[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h33, 8'h60};
    logic clk_sys = 1'b0, resetn = 1'b0, regWrEn = 1'b0, sleepReqPin = 1'b0;
    logic ioRailStrap = 1'b1, procRailStrap = 1'b0, chargerPgOn = 1'b0;
    logic cntClr = 1'b0, pgPinOut, pgPinOe, indBPinOut, indBPinOe;
    logic clkEn = 1'b1;
    reg_byte_t regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic fixedFreqForce, lowPowerMode, waitMode, ioRailEnable, motorDrive;
    logic ioRailDischarge, procRailEnable, procRailDischarge;
    logic [1:0] uvloSel, ioRailCode, lit;
    logic [2:0] procRailCode;
    logic [15:0] pgCnt = 16'h0000, indBCnt = 16'h0000;
    int mismatches = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h8455;
    note_t notes[$];
    event obsEv;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    indicator_blink_and_rail_config_regs #(.TICK_CYCLES(4))
    indicator_blink_and_rail_config_regs_i (
        .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
        .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .sleepReqPin(sleepReqPin),
        .ioRailStrap(ioRailStrap), .procRailStrap(procRailStrap),
        .chargerPgOn(chargerPgOn), .pgPinOut(pgPinOut), .pgPinOe(pgPinOe),
        .indBPinOut(indBPinOut), .indBPinOe(indBPinOe),
        .fixedFreqForce(fixedFreqForce), .uvloSel(uvloSel),
        .lowPowerMode(lowPowerMode), .waitMode(waitMode),
        .ioRailEnable(ioRailEnable), .ioRailDischarge(ioRailDischarge),
        .ioRailCode(ioRailCode), .procRailEnable(procRailEnable),
        .procRailDischarge(procRailDischarge), .procRailCode(procRailCode),
        .motorDrive(motorDrive));
    indicator_lamp_model indicator_lamp_model_i[1:0] (
        .pinOut({pgPinOut, indBPinOut}), .pinOe({pgPinOe, indBPinOe}),
        .lit(lit));
    always @(posedge clk_sys) begin
        pgCnt <= cntClr ? 16'h0000 : pgCnt + 16'(lit[1]);
        indBCnt <= cntClr ? 16'h0000 : indBCnt + 16'(lit[0]);
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        note_t nt;
        logic [15:0] got;
        forever begin
            @(obsEv);
            nt = notes.pop_front();
            case (nt.kind)
                0: got = {8'h00, regRdData};
                1: got = {14'h0000, lit};
                2: got = {10'h000, lowPowerMode, waitMode, ioRailEnable,
                    procRailEnable, ioRailDischarge, procRailDischarge};
                3: got = {13'h0000, procRailCode};
                4: got = {10'h000, motorDrive, fixedFreqForce, uvloSel,
                    ioRailCode};
                5: got = pgCnt;
                default: got = indBCnt;
            endcase
            `CHK(got, nt.exp, nt.what)
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // The pause keeps two notes of one time step from sharing one trigger.
    task automatic note(input int k, input logic [15:0] e, input string w);
        notes.push_back('{k, e, w});
        ->obsEv;
        #1;
    endtask
    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(posedge clk_sys);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask
    task automatic settle;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic rd(input reg_byte_t a, input reg_byte_t e, input string w);
        @(posedge clk_sys);
        regAddr <= a;
        settle();
        note(0, {8'h00, e}, w);
    endtask
    task automatic do_reset(input logic ioS, input logic prS);
        @(posedge clk_sys);
        resetn <= 1'b0;
        ioRailStrap <= ioS;
        procRailStrap <= prS;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic print_verdict;
        $display("counts: %0d compared, %0d wrong", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        $display("wrong value at %0t: run hung", $time);
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        reg_byte_t d;
        logic lp, wt;
        logic [15:0] ex;
        do_reset(1'b1, 1'b0);
        for (i = 0; i < 6; i++) begin
            rd(8'h08 + 8'(i), RV[i], "reset value");
        end
        rd(8'h0e, 8'h00, "unmapped");
        note(4, 16'h0007, "reset cfg");
        note(3, 16'h0006, "reset code");
        $display("done: reset");
        for (i = 0; i < 24; i++) begin
            seed = xs(seed);
            wr(8'h08 + 8'(i % 6), seed[7:0]);
            rd(8'h08 + 8'(i % 6), seed[7:0], "read back");
        end
        wr(8'h0f, 8'h5a);
        rd(8'h0f, 8'h00, "unmapped write");
        $display("done: access");
        for (i = 0; i < 16; i++) begin
            d = {i[0] ^ i[3], i[1:0], 3'b000, i[3:2]};
            wr(8'h0c, d);
            wr(8'h0d, {1'b0, i[2:0], 2'b10, i[3], 1'b0});
            settle();
            ex = {10'h000, i[3], d[7:5], d[1:0]};
            note(4, ex, "cfg");
            note(3, 16'(i[2:0]), "code");
        end
        $display("done: fields");
        for (i = 0; i < 16; i++) begin
            lp = i[1] & i[0];
            wt = i[1] & ~i[0];
            wr(8'h0c, {3'b001, i[0], i[1], i[3], 2'b10});
            wr(8'h0d, {i[2], 3'b101, 2'b01, 1'b0, i[3]});
            @(posedge clk_sys);
            sleepReqPin <= 1'b1;
            settle();
            ex = {10'h000, lp, wt, ~wt, ~wt & ~(lp & i[2]), i[3] & wt,
                i[3] & (wt | (lp & i[2]))};
            note(2, ex, "sleep");
            note(3, lp ? 16'h0001 : 16'h0005, "sleep code");
            @(posedge clk_sys);
            sleepReqPin <= 1'b0;
            settle();
            note(3, 16'h0005, "restored");
        end
        $display("done: sleep");
        for (i = 0; i < 8; i++) begin
            if (i / 2 != 1) begin
                @(posedge clk_sys);
                chargerPgOn <= i[0];
                wr(8'h08, {i[2], 7'h00});
                wr(8'h09, {i[1], 7'h00});
                wr(8'h0a, {i[2], 7'h00});
                wr(8'h0b, {i[1], 7'h00});
                settle();
                ex = {14'h0000, i[2] ? i[1] : i[0], i[2] & i[1]};
                note(1, ex, "mode");
            end
        end
        wr(8'h08, 8'h01);
        wr(8'h09, 8'h81);
        wr(8'h0a, 8'h03);
        wr(8'h0b, 8'h80);
        repeat (8) @(posedge clk_sys);
        cntClr <= 1'b1;
        @(posedge clk_sys);
        cntClr <= 1'b0;
        // The window spans whole periods of both, so phase does not matter.
        repeat (160) @(posedge clk_sys);
        @(negedge clk_sys);
        note(5, 16'h0010, "pg blink");
        note(6, 16'h0040, "b blink");
        $display("done: indicators");
        do_reset(1'b0, 1'b1);
        rd(8'h0c, 8'h32, "io strap");
        rd(8'h0d, 8'h70, "proc strap");
        // A write while the enable is low must leave every register alone.
        @(posedge clk_sys);
        clkEn <= 1'b0;
        wr(8'h0d, 8'h02);
        @(posedge clk_sys);
        clkEn <= 1'b1;
        rd(8'h0d, 8'h70, "frozen write");
        note(3, 16'h0007, "strap code");
        note(4, 16'h0006, "strap cfg");
        $display("done: straps");
        print_verdict();
    end
endmodule
